// ### cks_console.sv
// Purpose: Console end: turns operating keys and switches into control.
// Assumes: Keys and switches are raw asynchronous pins, active high.
// Notes:   One control sequence per press; keys only act when stopped.
// Operation
// - Address set drives switches, loads address register
// - Address set never starts a timing cycle
// - Field set loads field registers, no cycle
// - Store word selects console path, inhibits decode
// - Store word starts cycle after key delay
// - Processor loads counter at first pulse
// - Switch word gated during second time state
// - Halt request stops console cycle at TP3
// - Counter passed to address register at TP4
// - Inspect like store, adds memory data route
// - Inspect loads buffer from memory, rewrites
// - Inspect advances counter to next address
// - Resume asserts only cycle start
// - Clear key asserts system clear
// - Step switch holds halt request continuously
// - Halt switch requests halt before fetch
// - Highest priority key only, while held
// - Stopped only; gate after delay
module cks_console
   import cks_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   // Operator keys
   input  wire logic              addr_set_key_i,
   input  wire logic              field_set_key_i,
   input  wire logic              clear_key_i,
   input  wire logic              resume_key_i,
   input  wire logic              inspect_key_i,
   input  wire logic              store_word_key_i,
   // Operator switches
   input  wire logic              cycle_step_switch_i,
   input  wire logic              halt_switch_i,
   input  wire logic [WORD_W-1:0] switch_word_i,
   // Status
   output logic                   busy_o,
   // Backplane
   cks_bus_if.console             bus
);
   import cks_pkg::*;

   localparam int unsigned NKEY = 8;                 // Six keys plus two switches

   logic [NKEY-1:0]   meta_r;                        // First synchroniser stage
   logic [NKEY-1:0]   sync_r;                        // Second synchroniser stage
   logic [NKEY-1:0]   deb_r;                         // Debounced levels
   logic [CNT_W-1:0]  deb_cnt_r [NKEY];              // Per input stability count
   logic [WORD_W-1:0] sw_meta_r;                     // Switch word first stage
   logic [WORD_W-1:0] sw_sync_r;                     // Switch word second stage
   logic              run_meta_r;                    // Run level first stage
   logic              run_sync_r;                    // Run level second stage
   logic              fetch_meta_r;                  // Fetch level first stage
   logic              fetch_sync_r;                  // Fetch level second stage
   logic              ts2_meta_r;                    // Time state first stage
   logic              ts2_sync_r;                    // Time state second stage
   cks_key_t          key_r;                         // Key being sequenced
   cks_key_t          key_nxt;                       // Encoded top key
   logic [CNT_W-1:0]  cnt_r;                         // Delay and gate counter
   logic              gate_r;                        // Enable gate open
   logic              wait_r;                        // Waiting out the delay
   logic              done_r;                        // Sequence done, await release
   logic              start_ok;                      // Key may be accepted
   logic              in_gate;                       // Current key in gate
   logic              store_cyc_r;                   // Store word cycle pending

   typedef enum logic [1:0] {CKS_IDLE, CKS_WAIT, CKS_GATE, CKS_HOLD} cks_seq_t;
   cks_seq_t          seq_r;                         // Sequencer state

   // Two flop synchronisers on every pin
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         meta_r       <= '0;
         sync_r       <= '0;
         sw_meta_r    <= WORD_ZERO;
         sw_sync_r    <= WORD_ZERO;
         run_meta_r   <= 1'b0;
         run_sync_r   <= 1'b0;
         fetch_meta_r <= 1'b0;
         fetch_sync_r <= 1'b0;
         ts2_meta_r   <= 1'b0;
         ts2_sync_r   <= 1'b0;
      end
      else
      begin
         meta_r       <= {halt_switch_i, cycle_step_switch_i, store_word_key_i,
                          inspect_key_i, resume_key_i, clear_key_i,
                          field_set_key_i, addr_set_key_i};
         sync_r       <= meta_r;
         sw_meta_r    <= switch_word_i;
         sw_sync_r    <= sw_meta_r;
         run_meta_r   <= bus.running;
         run_sync_r   <= run_meta_r;
         fetch_meta_r <= bus.next_fetch;
         fetch_sync_r <= fetch_meta_r;
         ts2_meta_r   <= bus.time_state_two;
         ts2_sync_r   <= ts2_meta_r;
      end
   end

   // Debounce: accept a level once stable for a run of samples
   always_ff @(posedge clk_i)
   begin
      for (int i = 0; i < NKEY; i++)
      begin
         if (reset_i)
         begin
            deb_r[i]     <= 1'b0;
            deb_cnt_r[i] <= '0;
         end
         else if (sync_r[i] == deb_r[i])
         begin
            deb_cnt_r[i] <= '0;
         end
         else if (deb_cnt_r[i] == DEB_LAST)
         begin
            deb_r[i]     <= sync_r[i];
            deb_cnt_r[i] <= '0;
         end
         else
         begin
            deb_cnt_r[i] <= deb_cnt_r[i] + 1'b1;
         end
      end
   end

   // Priority encoder, address set highest
   always_comb
   begin
      key_nxt = CKS_KEY_NONE;
      if (deb_r[0])      key_nxt = CKS_KEY_ADDR_SET;
      else if (deb_r[1]) key_nxt = CKS_KEY_FIELD_SET;
      else if (deb_r[2]) key_nxt = CKS_KEY_CLEAR;
      else if (deb_r[3]) key_nxt = CKS_KEY_RESUME;
      else if (deb_r[4]) key_nxt = CKS_KEY_INSPECT;
      else if (deb_r[5]) key_nxt = CKS_KEY_STORE;
   end

   // Keys accepted only while the processor is stopped
   assign start_ok = (key_nxt != CKS_KEY_NONE) && !run_sync_r;
   assign in_gate  = (seq_r == CKS_GATE);

   // Key sequencer: delay, gate, then hold until release
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         seq_r <= CKS_IDLE;
         key_r <= CKS_KEY_NONE;
         cnt_r <= '0;
      end
      else
      begin
         case (seq_r)
            CKS_IDLE:
            begin
               cnt_r <= '0;
               if (start_ok)
               begin
                  key_r <= key_nxt;
                  seq_r <= CKS_WAIT;
               end
            end
            CKS_WAIT:
            begin
               if (key_nxt != key_r)
               begin
                  seq_r <= CKS_IDLE;                    // Released early
               end
               else if (cnt_r == DELAY_LAST)
               begin
                  cnt_r <= '0;
                  seq_r <= CKS_GATE;
               end
               else
               begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            CKS_GATE:
            begin
               if (key_nxt != key_r || cnt_r == GATE_LAST)
               begin
                  cnt_r <= '0;
                  seq_r <= CKS_HOLD;
               end
               else
               begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            CKS_HOLD:
            begin
               // One sequence per press; wait for all keys released
               if (key_nxt == CKS_KEY_NONE)
               begin
                  key_r <= CKS_KEY_NONE;
                  seq_r <= CKS_IDLE;
               end
            end
            default:
            begin
               seq_r <= CKS_IDLE;
            end
         endcase
      end
   end

   // Store word cycle tracking for switch gating in second time state
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         store_cyc_r <= 1'b0;
      else if (in_gate && key_r == CKS_KEY_STORE)
         store_cyc_r <= 1'b1;
      else if (seq_r == CKS_IDLE && !run_sync_r)
         store_cyc_r <= 1'b0;
   end

   // Control outputs, registered
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         bus.data_lines           <= WORD_ZERO;
         bus.data_drive           <= 1'b0;
         bus.load_path_enable     <= 1'b0;
         bus.state_decode_inhibit <= 1'b0;
         bus.console_path_select  <= 1'b0;
         bus.addr_load_strobe     <= 1'b0;
         bus.mem_data_route       <= 1'b0;
         bus.cycle_start          <= 1'b0;
         bus.system_clear         <= 1'b0;
         bus.halt_request         <= 1'b0;
         busy_o                   <= 1'b0;
      end
      else
      begin
         // Address and field set put switches out during the gate
         bus.data_drive <= (in_gate && (key_r == CKS_KEY_ADDR_SET ||
                                        key_r == CKS_KEY_FIELD_SET))
                           || (store_cyc_r && ts2_sync_r);
         bus.data_lines <= sw_sync_r;
         bus.load_path_enable     <= in_gate && (key_r == CKS_KEY_ADDR_SET ||
                                                 key_r == CKS_KEY_FIELD_SET);
         bus.addr_load_strobe     <= in_gate && (key_r == CKS_KEY_ADDR_SET ||
                                                 key_r == CKS_KEY_FIELD_SET);
         bus.state_decode_inhibit <= in_gate && (key_r == CKS_KEY_ADDR_SET ||
                                                 key_r == CKS_KEY_STORE ||
                                                 key_r == CKS_KEY_INSPECT);
         bus.console_path_select  <= in_gate && (key_r == CKS_KEY_FIELD_SET ||
                                                 key_r == CKS_KEY_STORE ||
                                                 key_r == CKS_KEY_INSPECT);
         bus.mem_data_route       <= in_gate && key_r == CKS_KEY_INSPECT;
         // Only cycle keys start a cycle; set keys never do
         bus.cycle_start          <= in_gate && (key_r == CKS_KEY_STORE ||
                                                 key_r == CKS_KEY_INSPECT ||
                                                 key_r == CKS_KEY_RESUME);
         bus.system_clear         <= in_gate && key_r == CKS_KEY_CLEAR;
         // Store and inspect gates raise halt request so key cycles are single
         bus.halt_request <= deb_r[6]
                             || (deb_r[7] && fetch_sync_r)
                             || (in_gate && (key_r == CKS_KEY_STORE ||
                                             key_r == CKS_KEY_INSPECT));
         busy_o <= (seq_r != CKS_IDLE);
      end
   end
endmodule

// ### cks_pkg.sv
// Purpose: Shared constants and types for the console key sequencer.
// Assumes: 20 MHz logic clock, 12-bit data word.
// Notes:   Used by both the console end and the datapath end.
package cks_pkg;
   localparam int unsigned CLK_PERIOD_NS = 50;     // Logic clock period
   localparam int unsigned WORD_W        = 12;     // Data word width
   localparam int unsigned FIELD_LO      = 6;      // Low switch bit of field set
   localparam int unsigned FIELD_W       = 3;      // Width of each field register
   localparam int unsigned KEY_DELAY_NS  = 1500;   // Key detect to enable gate
   localparam int unsigned GATE_NS       = 500;    // Enable gate length
   // Least time rounds up to whole cycles
   localparam int unsigned DELAY_CYC = (KEY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Longest time rounds down
   localparam int unsigned GATE_CYC  = (GATE_NS / CLK_PERIOD_NS) < 1 ? 1
                                       : (GATE_NS / CLK_PERIOD_NS);
   localparam int unsigned DEBOUNCE_CYC = 16;      // Stable samples to accept a key
   localparam int unsigned CNT_W     = 8;          // Width of timing counters
   localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(DELAY_CYC - 1);
   localparam logic [CNT_W-1:0] GATE_LAST  = CNT_W'(GATE_CYC - 1);
   localparam logic [CNT_W-1:0] DEB_LAST   = CNT_W'(DEBOUNCE_CYC - 1);
   localparam logic [WORD_W-1:0] WORD_ZERO = 12'h000;

   // Operating keys in priority order, address set highest
   typedef enum logic [2:0] {
      CKS_KEY_NONE,
      CKS_KEY_ADDR_SET,
      CKS_KEY_FIELD_SET,
      CKS_KEY_CLEAR,
      CKS_KEY_RESUME,
      CKS_KEY_INSPECT,
      CKS_KEY_STORE
   } cks_key_t;

   // Processor time states
   typedef enum logic [1:0] {
      CKS_TS1,
      CKS_TS2,
      CKS_TS3,
      CKS_TS4
   } cks_ts_t;
endpackage

// ### cks_bus_if.sv
// Purpose: Backplane signals between console and datapath.
// Assumes: All signals are active high and on one clock.
// Notes:   No clocking block; testbench joins the two ends.
interface cks_bus_if;
   import cks_pkg::*;
   logic [WORD_W-1:0] data_lines;            // Console word onto data lines
   logic              data_drive;            // Console drives data_lines
   logic              load_path_enable;      // Data lines through adder path
   logic              state_decode_inhibit;  // Zero on second adder input
   logic              console_path_select;   // Field register path instead of address register
   logic              addr_load_strobe;      // Load address strobe
   logic              mem_data_route;        // Memory data into adder
   logic              cycle_start;           // Start a timing cycle
   logic              system_clear;          // Clear the system
   logic              halt_request;          // Stop at third time pulse
   logic              running;               // Run flip-flop of processor
   logic              next_fetch;            // Next cycle is a fetch
   logic              time_state_two;        // Processor in second time state

   modport console (
      output data_lines, data_drive, load_path_enable, state_decode_inhibit,
             console_path_select, addr_load_strobe, mem_data_route,
             cycle_start, system_clear, halt_request,
      input  running, next_fetch, time_state_two
   );
   modport datapath (
      input  data_lines, data_drive, load_path_enable, state_decode_inhibit,
             console_path_select, addr_load_strobe, mem_data_route,
             cycle_start, system_clear, halt_request,
      output running, next_fetch, time_state_two
   );
endinterface

// ### cks_datapath.sv
// Purpose: Datapath end: minimal processor registers and memory.
// Assumes: Same clock as the console; time states advance one per clock.
// Notes:   Small memory model of the major registers for key cycles.
module cks_datapath
   import cks_pkg::*;
#(
   parameter int unsigned MEM_AW = 12                // Memory address width
)
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   // Processor status
   input  wire logic              next_fetch_i,
   // Register views
   output logic [WORD_W-1:0]      mem_addr_reg_o,
   output logic [WORD_W-1:0]      mem_buffer_reg_o,
   output logic [WORD_W-1:0]      prog_counter_o,
   output logic [FIELD_W-1:0]     instr_field_reg_o,
   output logic [FIELD_W-1:0]     operand_field_reg_o,
   output logic                   cleared_o,
   // Backplane
   cks_bus_if.datapath            bus
);
   import cks_pkg::*;

   logic [WORD_W-1:0] mem_r [2**MEM_AW];             // Memory array
   cks_ts_t           ts_r;                          // Time state
   logic              run_r;                         // Run flip-flop
   logic              halt_r;                        // Halt latched for cycle
   logic              route_r;                       // Inspect routing latched
   logic [WORD_W-1:0] ma_r;                          // Memory address register
   logic [WORD_W-1:0] mb_r;                          // Memory buffer register
   logic [WORD_W-1:0] pc_r;                          // Program counter
   logic [FIELD_W-1:0] if_r;                         // Instruction field
   logic [FIELD_W-1:0] df_r;                         // Operand field
   logic              start_q_r;                     // Cycle start seen last clock
   logic              cyc_on;                        // Timing cycle in progress

   // A cycle runs on through TS4 even once run is cleared at TS3
   assign cyc_on = run_r || (ts_r != CKS_TS1);

   // Adder with zero addend on console paths
   function automatic logic [WORD_W-1:0] add_zero(input logic [WORD_W-1:0] a);
      add_zero = a + WORD_ZERO;
   endfunction

   // Timing: one time state per clock while a cycle is on
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         run_r     <= 1'b0;
         ts_r      <= CKS_TS1;
         halt_r    <= 1'b0;
         route_r   <= 1'b0;
         start_q_r <= 1'b0;
      end
      else
      begin
         start_q_r <= bus.cycle_start;
         if (!cyc_on)
         begin
            ts_r <= CKS_TS1;
            // Leading edge only: the key gate outlasts a cycle and must not restart it
            if (bus.cycle_start && !start_q_r)
            begin
               run_r   <= 1'b1;
               halt_r  <= bus.halt_request;
               route_r <= bus.mem_data_route;
            end
         end
         else
         begin
            halt_r <= halt_r || bus.halt_request;
            case (ts_r)
               CKS_TS1: ts_r <= CKS_TS2;
               CKS_TS2: ts_r <= CKS_TS3;
               CKS_TS3:
               begin
                  ts_r <= CKS_TS4;
                  if (halt_r || bus.halt_request)
                     run_r <= 1'b0;
               end
               CKS_TS4:
               begin
                  ts_r    <= CKS_TS1;
                  halt_r  <= 1'b0;
                  route_r <= 1'b0;
               end
               default: ts_r <= CKS_TS1;
            endcase
         end
      end
   end

   // Major registers
   always_ff @(posedge clk_i)
   begin
      if (reset_i || bus.system_clear)
      begin
         ma_r <= WORD_ZERO;
         mb_r <= WORD_ZERO;
         pc_r <= WORD_ZERO;
         if_r <= '0;
         df_r <= '0;
      end
      else if (!cyc_on && bus.addr_load_strobe && bus.load_path_enable)
      begin
         if (bus.console_path_select)
         begin
            if_r <= bus.data_lines[FIELD_LO +: FIELD_W];
            df_r <= bus.data_lines[FIELD_LO+FIELD_W +: FIELD_W];
         end
         else
            ma_r <= add_zero(bus.data_lines);
      end
      else if (cyc_on)
      begin
         case (ts_r)
            CKS_TS1: pc_r <= ma_r + 1'b1;
            CKS_TS2:
            begin
               mb_r <= route_r ? add_zero(mem_r[ma_r[MEM_AW-1:0]])
                               : add_zero(bus.data_lines);
            end
            CKS_TS4: ma_r <= add_zero(pc_r);
            default: ;
         endcase
      end
   end

   // Write half: buffer written back at address
   always_ff @(posedge clk_i)
   begin
      if (cyc_on && ts_r == CKS_TS3)
         mem_r[ma_r[MEM_AW-1:0]] <= mb_r;
   end

   // Status outputs
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         bus.running         <= 1'b0;
         bus.next_fetch      <= 1'b0;
         bus.time_state_two  <= 1'b0;
         mem_addr_reg_o      <= WORD_ZERO;
         mem_buffer_reg_o    <= WORD_ZERO;
         prog_counter_o      <= WORD_ZERO;
         instr_field_reg_o   <= '0;
         operand_field_reg_o <= '0;
         cleared_o           <= 1'b0;
      end
      else
      begin
         bus.running         <= run_r;
         bus.next_fetch      <= next_fetch_i;
         bus.time_state_two  <= run_r && ts_r == CKS_TS2;
         mem_addr_reg_o      <= ma_r;
         mem_buffer_reg_o    <= mb_r;
         prog_counter_o      <= pc_r;
         instr_field_reg_o   <= if_r;
         operand_field_reg_o <= df_r;
         cleared_o           <= bus.system_clear;
      end
   end
endmodule

// ### cks_checker.sv
// Purpose: Assertions on the backplane between console and datapath.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Switch inputs are not visible here, so halt rules are left to the bench.
module cks_checker
   import cks_pkg::*;
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic reset_i,
   // Backplane
   input  wire logic data_drive,
   input  wire logic load_path_enable,
   input  wire logic state_decode_inhibit,
   input  wire logic console_path_select,
   input  wire logic addr_load_strobe,
   input  wire logic mem_data_route,
   input  wire logic cycle_start,
   input  wire logic system_clear,
   input  wire logic halt_request,
   input  wire logic running
);
   logic [CNT_W-1:0] gate_cnt_r;   // Cycles a key control has stood

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   // A counter, because a gate of this length is too long to unroll
   always_ff @(posedge clk_i)
   begin
      if (reset_i || !(cycle_start || addr_load_strobe || system_clear))
         gate_cnt_r <= '0;
      else
         gate_cnt_r <= gate_cnt_r + 8'h01;
   end

   addr_no_cycle_a:
      assert property (addr_load_strobe |-> !cycle_start)
      else $error("address load started a timing cycle");
   addr_path_a:
      assert property (addr_load_strobe |-> load_path_enable && data_drive)
      else $error("address load without data path");
   store_ctrl_a:
      assert property (cycle_start && console_path_select |-> state_decode_inhibit && halt_request)
      else $error("console cycle without inhibit or halt");
   resume_only_a:
      assert property (cycle_start && !console_path_select
                       |-> !(state_decode_inhibit || mem_data_route || load_path_enable))
      else $error("resume raised more than cycle start");
   inspect_route_a:
      assert property (mem_data_route |-> cycle_start && console_path_select && !data_drive)
      else $error("memory route outside an inspect gate");
   clear_alone_a:
      assert property (system_clear |-> !cycle_start && !addr_load_strobe && !console_path_select)
      else $error("clear mixed with other controls");
   start_stopped_a:
      assert property ($rose(cycle_start) |-> !running)
      else $error("cycle start while running");
   gate_len_a:
      assert property ((cycle_start || addr_load_strobe || system_clear) |-> gate_cnt_r <= GATE_LAST)
      else $error("key control stood past the gate");
endmodule

// ### console_key_sequencer_test.sv
// Purpose: Key sequences through both ends joined by the backplane.
// Assumes: Keys held long enough to pass debounce and delay.
// Notes:   Expected registers follow the key actions, not design outputs.
module console_key_sequencer_test;
   timeunit 1ns;
   timeprecision 1ns;
   import cks_pkg::*;

   logic                 clk_i   = 1'b0;
   logic                 reset_i = 1'b1;
   logic [5:0]           keys_r  = 6'h00;   // Addr, field, clear, resume, inspect, store
   logic                 step_r  = 1'b0;    // Cycle step switch
   logic                 halt_r  = 1'b0;    // Halt switch
   logic                 fetch_r = 1'b0;    // Next cycle is a fetch
   logic [WORD_W-1:0]    sw_r    = 12'h000; // Switch word
   logic                 busy, cleared, run_q = 1'b0, start_q = 1'b0, clr_seen = 1'b0;
   logic [WORD_W-1:0]    ma, mb, pc;
   logic [FIELD_W-1:0]   ifr, dfr;
   int                   miscompares = 0, check_count = 0;
   int                   cyc = 0, t0 = 0, t_start = 0, runs = 0;

   // Free-running clock
   always #25 clk_i = ~clk_i;

   cks_bus_if bus_if();
   cks_console i_cks_console(.clk_i(clk_i), .reset_i(reset_i), .addr_set_key_i(keys_r[0]),
      .field_set_key_i(keys_r[1]), .clear_key_i(keys_r[2]), .resume_key_i(keys_r[3]),
      .inspect_key_i(keys_r[4]), .store_word_key_i(keys_r[5]), .cycle_step_switch_i(step_r),
      .halt_switch_i(halt_r), .switch_word_i(sw_r), .busy_o(busy), .bus(bus_if));
   cks_datapath i_cks_datapath(.clk_i(clk_i), .reset_i(reset_i), .next_fetch_i(fetch_r),
      .mem_addr_reg_o(ma), .mem_buffer_reg_o(mb), .prog_counter_o(pc),
      .instr_field_reg_o(ifr), .operand_field_reg_o(dfr), .cleared_o(cleared), .bus(bus_if));
   cks_checker i_cks_checker(.clk_i(clk_i), .reset_i(reset_i), .data_drive(bus_if.data_drive),
      .load_path_enable(bus_if.load_path_enable), .running(bus_if.running),
      .state_decode_inhibit(bus_if.state_decode_inhibit),
      .console_path_select(bus_if.console_path_select),
      .addr_load_strobe(bus_if.addr_load_strobe), .mem_data_route(bus_if.mem_data_route),
      .cycle_start(bus_if.cycle_start), .system_clear(bus_if.system_clear),
      .halt_request(bus_if.halt_request));

   // Count clocks and run starts, and note when a cycle start first appears
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      run_q <= bus_if.running;
      start_q <= bus_if.cycle_start;
      if (bus_if.running === 1'b1 && run_q !== 1'b1)
         runs <= runs + 1;
      if (bus_if.cycle_start === 1'b1 && start_q !== 1'b1)
         t_start <= cyc;
      if (cleared === 1'b1)
         clr_seen <= 1'b1;
   end

   task check(string name, logic [WORD_W-1:0] seen, logic [WORD_W-1:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   // Hold keys past debounce, delay and gate, then let go of all of them
   task press(logic [5:0] k, logic [WORD_W-1:0] w);
      @(posedge clk_i);
      sw_r <= w;
      keys_r <= k;
      t0 = cyc;
      runs = 0;
      repeat (80) @(posedge clk_i);
      keys_r <= 6'h00;
   endtask

   // Bounded wait for console and processor to stop
   task settle();
      int n;
      n = 0;
      while (n < 300 && !(busy === 1'b0 && bus_if.running === 1'b0))
      begin
         @(posedge clk_i);
         n++;
      end
      check("idle", {11'h000, n < 300}, 12'h001);
      repeat (4) @(posedge clk_i);
   endtask

   task finish_test();
      $display("Counts: %0d checks, %0d mismatches", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Key sequences
   initial
   begin
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      press(6'h01, 12'h5a3);
      settle();
      check("ma", ma, 12'h5a3);
      check("runs", 12'(runs), 12'h000);
      press(6'h02, 12'h9c0);
      settle();
      check("ifr", {9'h000, ifr}, 12'h007);
      check("dfr", {9'h000, dfr}, 12'h004);
      check("ma", ma, 12'h5a3);
      $display("test address and field set done");
      press(6'h20, 12'h3c7);
      settle();
      check("mb", mb, 12'h3c7);
      check("pc", pc, 12'h5a4);
      check("ma", ma, 12'h5a4);
      check("runs", 12'(runs), 12'h001);
      check("delay", {11'h000, (t_start - t0) >= DELAY_CYC}, 12'h001);
      $display("test store word done");
      press(6'h20, 12'h0f0);
      settle();
      check("pc", pc, 12'h5a5);
      press(6'h01, 12'h5a3);
      settle();
      press(6'h10, 12'h000);
      settle();
      check("mb", mb, 12'h3c7);
      check("pc", pc, 12'h5a4);
      check("runs", 12'(runs), 12'h001);
      $display("test inspect done");
      press(6'h21, 12'h123);
      settle();
      check("ma", ma, 12'h123);
      check("runs", 12'(runs), 12'h000);
      press(6'h04, 12'h000);
      settle();
      check("cleared", {11'h000, clr_seen}, 12'h001);
      $display("test priority and clear done");
      step_r <= 1'b1;
      press(6'h08, 12'h000);
      settle();
      check("runs", 12'(runs), 12'h001);
      step_r <= 1'b0;
      halt_r <= 1'b1;
      press(6'h08, 12'h000);
      check("running", {11'h000, bus_if.running}, 12'h001);
      fetch_r <= 1'b1;
      settle();
      check("runs", 12'(runs), 12'h001);
      $display("test step and halt done");
      finish_test();
   end

   // Watchdog well past the expected run length
   initial
   begin
      #(20000 * CLK_PERIOD_NS);
      miscompares++;
      finish_test();
   end
endmodule
